// ==== design/stsq_defines.svh ====
`ifndef STSQ_DEFINES_SVH
`define STSQ_DEFINES_SVH
// register byte offsets
`define STSQ_OFF_CTRL 8'h00
`define STSQ_OFF_CMD 8'h04
`define STSQ_OFF_REPEAT 8'h08
`define STSQ_OFF_WLEN 8'h0c
`define STSQ_OFF_LSEG 8'h10
`define STSQ_OFF_STATUS 8'h14
// ctrl fields
`define STSQ_CTRL_SRC_LSB 0
`define STSQ_CTRL_FALL_BIT 4
`define STSQ_CTRL_MODE_LSB 5
`define STSQ_CTRL_SEQ_BIT 7
// command bits
`define STSQ_CMD_INIT_BIT 0
`define STSQ_CMD_SW_BIT 1
`define STSQ_CMD_ABORT_BIT 2
// source codes
`define STSQ_SRC_IMM 4'h0
`define STSQ_SRC_SW 4'h1
`define STSQ_SRC_EXT_FIRST 4'h2
`define STSQ_SRC_EXT_LAST 4'hb
// reset values
`define STSQ_RST_REPEAT 16'h0000
`define STSQ_RST_WLEN 16'h00ff
`define STSQ_RST_LSEG 8'h00
// number of synchronised external trigger inputs
`define STSQ_N_EXT 10
`endif

// ==== design/stsq_pkg.sv ====
package stsq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_HOLD} stsq_state_t;
  typedef enum logic [1:0] {TM_SINGLE, TM_CONT, TM_STEP, TM_BURST} stsq_tmode_t;

  typedef struct packed {
    logic [7:0] seg;
    logic [15:0] samp;
    logic wave_end;
  } stsq_play_t;

  typedef struct packed {
    logic [3:0] src;
    logic fall;
    stsq_tmode_t tmode;
    logic seq;
    logic [15:0] repeat_cnt;
    logic [15:0] wlen;
    logic [7:0] last_seg;
  } stsq_cfg_t;

  typedef struct packed {
    stsq_state_t st;
    stsq_cfg_t cfg;
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [9:0] sync3;
    logic consumed;
    logic [7:0] seg;
    logic [15:0] samp;
    logic [15:0] rep;
    logic ack;
    logic [31:0] rdat;
    logic v0;
    logic v1;
    stsq_play_t e0;
    stsq_play_t e1;
    logic hold;
  } stsq_reg_t;
endpackage

// ==== design/stsq_sequencer.sv ====
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "stsq_defines.svh"

module stsq_sequencer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // external trigger inputs
  input wire logic front_trigger_input_a_i,
  input wire logic front_trigger_input_b_i,
  input wire logic [7:0] backplane_trigger_i,
  // playback stream
  output logic play_valid_o,
  output stsq_pkg::stsq_play_t play_data_o,
  input wire logic play_ready_i,
  // status
  output logic hold_last_o
);

  stsq_pkg::stsq_reg_t q;
  stsq_pkg::stsq_reg_t d;

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic acc;
  logic wr;
  logic init_cmd;
  logic sw_cmd;
  logic abort_cmd;
  logic [9:0] rise;
  logic [9:0] fall;
  logic [9:0] edges;
  logic [3:0] ext_idx;
  logic trig;
  logic start;
  logic push;
  logic pop;
  logic wave_end;
  logic pass_end;
  logic [31:0] ctrl_rd;
  logic [31:0] wv;
  stsq_pkg::stsq_play_t pw;

  always_comb begin
    d = q;
    wv = 32'h0000_0000;
    pw = '0;
    push = 1'b0;
    pass_end = 1'b0;

    // ==========================================================
    // wishbone slave: ack one cycle after request, dropped next
    acc = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = acc & wb_we_i;
    d.ack = acc;
    init_cmd = wr && wb_adr_i == `STSQ_OFF_CMD && wb_sel_i[0] && wb_dat_i[`STSQ_CMD_INIT_BIT];
    sw_cmd = wr && wb_adr_i == `STSQ_OFF_CMD && wb_sel_i[0] && wb_dat_i[`STSQ_CMD_SW_BIT];
    abort_cmd = wr && wb_adr_i == `STSQ_OFF_CMD && wb_sel_i[0] && wb_dat_i[`STSQ_CMD_ABORT_BIT];

    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`STSQ_CTRL_SRC_LSB +: 4] = q.cfg.src;
    ctrl_rd[`STSQ_CTRL_FALL_BIT] = q.cfg.fall;
    ctrl_rd[`STSQ_CTRL_MODE_LSB +: 2] = q.cfg.tmode;
    ctrl_rd[`STSQ_CTRL_SEQ_BIT] = q.cfg.seq;

    if (wr) begin
      unique case (wb_adr_i)
        `STSQ_OFF_CTRL: begin
          wv = merge(ctrl_rd, wb_dat_i, wb_sel_i);
          d.cfg.src = wv[`STSQ_CTRL_SRC_LSB +: 4];
          d.cfg.fall = wv[`STSQ_CTRL_FALL_BIT];
          d.cfg.tmode = stsq_pkg::stsq_tmode_t'(wv[`STSQ_CTRL_MODE_LSB +: 2]);
          d.cfg.seq = wv[`STSQ_CTRL_SEQ_BIT];
        end
        `STSQ_OFF_REPEAT: begin
          wv = merge({16'h0000, q.cfg.repeat_cnt}, wb_dat_i, wb_sel_i);
          d.cfg.repeat_cnt = wv[15:0];
        end
        `STSQ_OFF_WLEN: begin
          wv = merge({16'h0000, q.cfg.wlen}, wb_dat_i, wb_sel_i);
          d.cfg.wlen = wv[15:0];
        end
        `STSQ_OFF_LSEG: begin
          wv = merge({24'h00_0000, q.cfg.last_seg}, wb_dat_i, wb_sel_i);
          d.cfg.last_seg = wv[7:0];
        end
        default: begin
        end
      endcase
    end

    if (acc) begin
      unique case (wb_adr_i)
        `STSQ_OFF_CTRL: d.rdat = ctrl_rd;
        `STSQ_OFF_REPEAT: d.rdat = {16'h0000, q.cfg.repeat_cnt};
        `STSQ_OFF_WLEN: d.rdat = {16'h0000, q.cfg.wlen};
        `STSQ_OFF_LSEG: d.rdat = {24'h00_0000, q.cfg.last_seg};
        `STSQ_OFF_STATUS: d.rdat = {16'h0000, q.seg, 4'h0, q.consumed, q.hold, q.st};
        default: d.rdat = 32'h0000_0000;
      endcase
    end

    // ==========================================================
    // trigger synchronisers and edge detect
    d.sync1 = {backplane_trigger_i, front_trigger_input_b_i, front_trigger_input_a_i};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    rise = q.sync2 & ~q.sync3;
    fall = ~q.sync2 & q.sync3;
    edges = q.cfg.fall ? fall : rise;
    ext_idx = q.cfg.src - `STSQ_SRC_EXT_FIRST;
    if (q.cfg.src == `STSQ_SRC_SW) begin
      trig = sw_cmd;
    end else if (q.cfg.src >= `STSQ_SRC_EXT_FIRST && q.cfg.src <= `STSQ_SRC_EXT_LAST) begin
      trig = edges[ext_idx];
    end else begin
      trig = 1'b0;
    end

    // ==========================================================
    // two-entry play buffer, pop side first
    pop = q.v0 & play_ready_i;
    if (pop) begin
      d.e0 = q.e1;
      d.v0 = q.v1;
      d.v1 = 1'b0;
    end

    // ==========================================================
    // sequencer
    wave_end = q.samp == q.cfg.wlen;
    start = 1'b0;
    unique case (q.st)
      stsq_pkg::ST_IDLE: begin
        // triggers of every source are dropped here
        if (init_cmd) begin
          d.st = stsq_pkg::ST_ARMED;
          d.consumed = 1'b0;
          d.hold = 1'b0;
        end
      end
      stsq_pkg::ST_ARMED: begin
        start = (q.cfg.src == `STSQ_SRC_IMM) | trig;
        if (start) begin
          d.consumed = 1'b1;
          d.st = stsq_pkg::ST_RUN;
          d.seg = 8'h00;
          d.samp = 16'h0000;
          d.rep = 16'h0000;
          d.hold = 1'b0;
        end
      end
      stsq_pkg::ST_RUN: begin
        // triggers during playback are ignored in every mode
        push = ~q.v1;
        if (push) begin
          pw.seg = q.seg;
          pw.samp = q.samp;
          pw.wave_end = wave_end;
          d.samp = q.samp + 16'h0001;
          if (wave_end) begin
            d.samp = 16'h0000;
            if (!q.cfg.seq) begin
              if (q.rep != q.cfg.repeat_cnt) begin
                d.rep = q.rep + 16'h0001;
              end else begin
                d.rep = 16'h0000;
                pass_end = 1'b1;
              end
            end else begin
              if (q.seg == q.cfg.last_seg) begin
                d.seg = 8'h00;
                pass_end = 1'b1;
              end else begin
                d.seg = q.seg + 8'h01;
                pass_end = q.cfg.tmode == stsq_pkg::TM_STEP;
              end
            end
            if (pass_end) begin
              unique case (q.cfg.tmode)
                stsq_pkg::TM_SINGLE: begin
                  d.st = stsq_pkg::ST_HOLD;
                  d.seg = q.seg;
                end
                stsq_pkg::TM_STEP: d.st = stsq_pkg::ST_HOLD;
                stsq_pkg::TM_CONT: d.st = stsq_pkg::ST_RUN;
                stsq_pkg::TM_BURST: d.st = stsq_pkg::ST_RUN;
              endcase
            end
          end
        end
      end
      stsq_pkg::ST_HOLD: begin
        // consumer keeps the final sample; no timeout
        d.hold = 1'b1;
        if (q.cfg.tmode == stsq_pkg::TM_STEP && trig) begin
          d.st = stsq_pkg::ST_RUN;
          d.hold = 1'b0;
        end
      end
    endcase
    if (init_cmd && q.st != stsq_pkg::ST_IDLE) begin
      // re-initiate restarts arming without losing queued words
      d.st = stsq_pkg::ST_ARMED;
      d.consumed = 1'b0;
      d.hold = 1'b0;
    end
    if (abort_cmd) begin
      d.st = stsq_pkg::ST_IDLE;
      d.hold = 1'b0;
    end

    // buffer push after pop so a one-entry buffer drains and refills in one cycle; no push while both entries are valid
    if (push) begin
      if (!d.v0) begin
        d.e0 = pw;
        d.v0 = 1'b1;
      end else begin
        d.e1 = pw;
        d.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= stsq_pkg::ST_IDLE;
      q.cfg.tmode <= stsq_pkg::TM_SINGLE;
      q.cfg.repeat_cnt <= `STSQ_RST_REPEAT;
      q.cfg.wlen <= `STSQ_RST_WLEN;
      q.cfg.last_seg <= `STSQ_RST_LSEG;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign play_valid_o = q.v0;
  assign play_data_o = q.e0;
  assign hold_last_o = q.hold;

endmodule

// ==== tb/stsq_sequencer_properties.sv ====
`timescale 1ns/1ps
`include "stsq_defines.svh"
// ====================
// port checker
module stsq_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // stream
  input wire logic play_valid_o,
  input wire stsq_pkg::stsq_play_t play_data_o,
  input wire logic play_ready_i,
  input wire logic hold_last_o
);
  logic cmd_q;
  logic first_q;
  // any command write counts; weaker than initiate alone but needs no data port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      cmd_q <= cmd_q | (wb_ack_o & wb_we_i & (wb_adr_i == `STSQ_OFF_CMD));
      first_q <= first_q & ~play_valid_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack stuck");
  property p_cmd0; wb_ack_o && !wb_we_i && wb_adr_i == `STSQ_OFF_CMD |-> wb_dat_o == 32'h0; endproperty
  a_cmd0: assert property (p_cmd0) else $error("cmd read");
  property p_quiet; $fell(rst_i) |-> !wb_ack_o && !play_valid_o && !hold_last_o; endproperty
  a_quiet: assert property (p_quiet) else $error("reset");
  property p_early; $rose(play_valid_o) |-> cmd_q; endproperty
  a_early: assert property (p_early) else $error("early play");
  property p_stand; play_valid_o && !play_ready_i |=> play_valid_o && $stable(play_data_o); endproperty
  a_stand: assert property (p_stand) else $error("word lost");
  property p_step; play_valid_o && play_ready_i && !play_data_o.wave_end ##1 play_valid_o && play_ready_i
    |-> play_data_o.samp == $past(play_data_o.samp) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("sample skip");
  property p_first; $rose(play_valid_o) && first_q |-> play_data_o.samp == 16'h0 && play_data_o.seg == 8'h0;
  endproperty
  a_first: assert property (p_first) else $error("bad start");
endmodule
bind stsq_sequencer stsq_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .play_valid_o, .play_data_o, .play_ready_i, .hold_last_o);

// ==== tb/stsq_trig_model.sv ====
`timescale 1ns/1ps
// ====================
// trigger source, lines idle low as if pulled down
module stsq_trig_model (
  // control
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [3:0] idx_i,
  // lines: front a, front b, backplane 0..7
  output logic [9:0] lines_o
);
  logic [1:0] cnt_q = 2'h0;
  initial lines_o = 10'h000;
  always @(posedge clk_i) begin
    if (fire_i) begin
      lines_o <= 10'h001 << idx_i;
      cnt_q <= 2'h3;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
      if (cnt_q == 2'h1) lines_o <= 10'h000;
    end
  end
endmodule

// ==== tb/tb_start_trigger_mode_sequencer.sv ====
`timescale 1ns/1ps
`include "stsq_defines.svh"
module tb_start_trigger_mode_sequencer;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [9:0] lines;
  logic play_valid_o;
  stsq_pkg::stsq_play_t play_data_o;
  logic play_ready_i = 1'b0;
  logic hold_last_o;
  logic fire = 1'b0;
  logic [3:0] idx = 4'h0;
  logic [24:0] exp_q[$];
  logic strict = 1'b1;
  logic [31:0] rdv;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h3c};
  int w;
  int miscompares = 0;
  int checks_done = 0;
  always #2.5 clk_i = ~clk_i;
  stsq_sequencer DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .front_trigger_input_a_i(lines[0]), .front_trigger_input_b_i(lines[1]),
    .backplane_trigger_i(lines[9:2]), .play_valid_o, .play_data_o, .play_ready_i, .hold_last_o);
  stsq_trig_model u_trig (.clk_i(clk_i), .fire_i(fire), .idx_i(idx), .lines_o(lines));
  // ====================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic trig(input int k);
    if (k == 1) wb(1'b1, `STSQ_OFF_CMD, 32'h2);
    else begin
      @(posedge clk_i);
      fire <= 1'b1;
      idx <= 4'(k - 2);
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask
  task automatic go(input int ctrl, input int rep, input int lseg, input int wl);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // cleared only once reset blocks the monitor, so a running stream cannot race it
    exp_q.delete();
    strict = 1'b1;
    rst_i <= 1'b0;
    if (ctrl < 0) return;
    wb(1'b1, `STSQ_OFF_CTRL, 32'(ctrl));
    wb(1'b1, `STSQ_OFF_REPEAT, 32'(rep));
    wb(1'b1, `STSQ_OFF_LSEG, 32'(lseg));
    wb(1'b1, `STSQ_OFF_WLEN, 32'(wl));
  endtask
  task automatic pass(input int seg, input int wl);
    for (int s = 0; s <= wl; s++) exp_q.push_back({8'(seg), 16'(s), s == wl});
  endtask
  // extra words after the queue empties show up during the settle wait
  task automatic drain();
    while (exp_q.size() != 0) @(posedge clk_i);
    repeat (12) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (!rst_i && play_valid_o === 1'b1 && play_ready_i === 1'b1) begin
      if (exp_q.size() != 0) chk(32'(play_data_o), 32'(exp_q.pop_front()));
      else if (strict) chk(32'(play_data_o), 32'h1ffffff);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
  // ====================
  // tests
  initial begin
    void'($urandom(58));
    fork
      forever @(posedge clk_i) play_ready_i <= ($urandom % 4) != 0;
    join_none
    go(-1, 0, 0, 0);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, ra[i], 32'h0);
      chk(rdv, (i == 3) ? 32'hff : 32'h0);
    end
    wb(1'b1, `STSQ_OFF_CTRL, 32'he5);
    wb(1'b0, `STSQ_OFF_CTRL, 32'h0);
    chk(rdv, 32'he5);
    wb_sel_i <= 4'h1;
    wb(1'b1, `STSQ_OFF_WLEN, 32'h1234);
    wb_sel_i <= 4'hf;
    wb(1'b0, `STSQ_OFF_WLEN, 32'h0);
    chk(rdv, 32'h34);
    $display("test 1 done");
    for (int s = 0; s < 2; s++) begin
      w = $urandom % 4 + 1;
      go(s << 7, 2, 2, w);
      for (int p = 0; p < 3; p++) pass(s ? p : 0, w);
      wb(1'b1, `STSQ_OFF_CMD, 32'h1);
      trig(1);
      drain();
      chk(32'(hold_last_o), 32'h1);
      wb(1'b0, `STSQ_OFF_STATUS, 32'h0);
      chk(rdv, s ? 32'h20f : 32'h00f);
    end
    $display("test 2 done");
    for (int k = 1; k < 12; k++) begin
      go(k | ((k % 2) << 4), 0, 0, 3);
      trig(k);
      repeat (10) @(posedge clk_i);
      pass(0, 3);
      wb(1'b1, `STSQ_OFF_CMD, 32'h1);
      trig(k);
      // a rising edge has started play by now, a falling one not yet
      chk(32'(play_valid_o), 32'(k % 2 == 0));
      trig(k);
      drain();
    end
    $display("test 3 done");
    for (int c = 0; c < 4; c++) begin
      go(32'h21 | ((c / 2) << 6) | ((c % 2) << 7), 0, 2, 2);
      for (int p = 0; p < 7; p++) pass((c % 2) ? p % 3 : 0, 2);
      wb(1'b1, `STSQ_OFF_CMD, 32'h1);
      trig(1);
      trig(1);
      strict = 1'b0;
      drain();
      wb(1'b1, `STSQ_OFF_CMD, 32'h4);
      wb(1'b0, `STSQ_OFF_STATUS, 32'h0);
      chk(rdv & 32'hf, 32'h8);
    end
    $display("test 4 done");
    for (int s = 0; s < 2; s++) begin
      go(32'h41 | (s << 7), 0, 1, 7);
      wb(1'b1, `STSQ_OFF_CMD, 32'h1);
      for (int p = 0; p < 2; p++) begin
        pass(s ? p : 0, 7);
        trig(1);
        trig(1);
        drain();
        chk(32'(hold_last_o), 32'h1);
      end
    end
    $display("test 5 done");
    give_verdict();
  end
endmodule
